// ---- rtl/sanitize_defines.svh ----
`ifndef SANITIZE_DEFINES_SVH
`define SANITIZE_DEFINES_SVH

// ============================================================
// Register byte offsets
`define SAN_OFF_COMMAND  8'h00
`define SAN_OFF_PARAM    8'h04
`define SAN_OFF_PATTERN  8'h08
`define SAN_OFF_RESULT   8'h0c
`define SAN_OFF_LBA_OUT  8'h10
`define SAN_OFF_EVENT    8'h14
`define SAN_OFF_CONFIG   8'h18

// ============================================================
// Command register fields
`define SAN_CMD_CODE_LSB   0
`define SAN_CMD_LOG_LSB    8
`define SAN_CMD_FEAT_LSB   16

// Parameter register fields
`define SAN_PAR_CLASS_LSB  0
`define SAN_PAR_FAILMODE   2
`define SAN_PAR_CLEARFAIL  3
`define SAN_PAR_INVERT     4
`define SAN_PAR_PASS_LSB   8

// Result register fields
`define SAN_RES_DONE       0
`define SAN_RES_ABORTED    1
`define SAN_RES_ERROR      2
`define SAN_RES_COMPLETED  3
`define SAN_RES_PAUSED     4
`define SAN_RES_STATE_LSB  8
`define SAN_RES_PCT_LSB    16

// Event register fields (write one to signal)
`define SAN_EVT_HARD       0
`define SAN_EVT_POWER_ON   1
`define SAN_EVT_SOFT       2

// Config register fields
`define SAN_CFG_ENCRYPT    0
`define SAN_CFG_STANDBY    1

// ============================================================
// Command codes
`define SAN_CODE           8'hb4
`define SAN_FEAT_STATUS    16'h0000
`define SAN_FEAT_CRYPTO    16'h0011
`define SAN_FEAT_OVERWRITE 16'h0014
`define SAN_FEAT_FREEZE    16'h0020
`define SAN_LOG_A          8'he0
`define SAN_LOG_B          8'h30
`define SAN_LOG_C          8'h10

// ============================================================
// Reset values and answers
`define SAN_CONFIG_RESET   2'h0
`define SAN_PCT_DONE       7'h64
`define SAN_RESP_OKAY      2'h0
`define SAN_RESP_SLVERR    2'h2

`endif

// ---- rtl/sanitize_pkg.sv ----
package sanitize_pkg;

	// ============================================================
	// Machine states, encoded idle 0 .. succeeded 4 by order
	typedef enum logic [2:0]
	{
		state_idle,
		state_frozen,
		state_operating,
		state_failed,
		state_succeeded
	} san_state_type;

	// Command class, tagged by the command front end
	typedef enum logic [1:0]
	{
		class_other,
		class_exempt,
		class_log_read,
		class_media
	} cmd_class_type;

endpackage : sanitize_pkg

// ---- rtl/progress_tracker.sv ----
`timescale 1ns/1ns
`include "sanitize_defines.svh"

// ============================================================
// Completion percentage of the running operation
module progress_tracker
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       start,
	input  wire logic       finish,
	input  wire logic       running,
	input  wire logic [6:0] engine_percent,
	output logic      [6:0] percent
);

	typedef struct packed
	{
		logic [6:0] percent;
	} progress_state_type;

	progress_state_type current;
	progress_state_type next_state;

	// Clamp to the done figure; a stale engine value never goes backwards
	always_comb
	begin
		next_state = current;
		if (start)
			next_state.percent = 7'h00;
		else if (finish)
			next_state.percent = `SAN_PCT_DONE;
		else if (running && engine_percent > current.percent)
			next_state.percent = (engine_percent > `SAN_PCT_DONE) ?
				`SAN_PCT_DONE : engine_percent;
	end

	// Register the state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			current <= '0;
		else
			current <= next_state;
	end

	assign percent = current.percent;

endmodule : progress_tracker

// ---- rtl/sanitize_state_machine.sv ----
// What this block does
// - Code b4 with feature 0011 is crypto scramble, 0014 is overwrite.
// - Status query (feature 0000) reports state and completion percentage.
// - Freeze-lock (0020) enters frozen from idle; later scramble or overwrite aborts.
// - Frozen aborts operation commands; status query leaves frozen unchanged.
// - Hardware or power-on reset returns frozen to idle.
// - Idle stays idle across resets and status; accepts operations or freeze.
// - Good operation command enters operating from idle, succeeded or failed.
// - Operation keeps running after its starting command has completed.
// - While operating, abort all commands outside the fixed allow-list.
// - Software reset, hardware reset or status never leave operating.
// - Power-on reset during an operation continues that operation.
// - Standby power-up resumes on a media access command, which fails.
// - Clean finish enters succeeded; status then reports completed without error.
// - Unsanitized sectors enter failed; status errors with unsuccessful code.
// - Inaccessible sectors left unsanitized are not an operation failure.
// - Failed clears only with failure-mode start and clearing status query.
// - Succeeded returns to idle on hardware, power-on reset or status.
// - Overwrite uses four-byte pattern, pass count and optional inversion.
// - Crypto scramble only on encrypting models; otherwise only overwrite.
// - Operations purge user data caches, leave non-user areas alone.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "sanitize_defines.svh"

module sanitize_state_machine
#(
	parameter int          PASS_WIDTH     = 4,
	// Arbitrary value for the unsuccessful-command code
	parameter logic [31:0] UNSUCCESS_CODE = 32'h0000_0001
)
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Media erase engine
	output logic                       engine_start,
	output logic                       engine_run,
	output logic                       engine_crypto,
	output logic                       engine_purge_cache,
	output logic [31:0]                engine_pattern,
	output logic [PASS_WIDTH-1:0]      engine_passes,
	output logic                       engine_invert,
	input  wire logic                  engine_done,
	input  wire logic                  engine_ok,
	input  wire logic [6:0]            engine_percent,
	// Machine state for the rest of the device
	output sanitize_pkg::san_state_type state
);

	// ============================================================
	// Parameter check
	if (PASS_WIDTH < 1 || PASS_WIDTH > 8)
	begin : bad_pass_width
		$error("PASS_WIDTH must lie between 1 and 8");
	end

	// ============================================================
	// State
	typedef struct packed
	{
		sanitize_pkg::san_state_type state;
		logic                        paused;
		logic                        run;
		logic                        fail_mode;
		logic                        crypto;
		logic                        invert;
		logic [PASS_WIDTH-1:0]       passes;
		logic                        start;
		logic [1:0]                  config_bits;
		logic [31:0]                 param;
		logic [31:0]                 pattern;
		logic                        done;
		logic                        aborted;
		logic                        error;
		logic                        completed;
		logic [31:0]                 lba_out;
		logic                        aw_held;
		logic                        w_held;
		logic [7:0]                  awaddr;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        arready;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
	} machine_type;

	machine_type current;
	machine_type next_state;
	logic [6:0]  percent;
	logic        finish;

	// Engine result only counts while the operation is live
	assign finish = engine_done && current.state ==
		sanitize_pkg::state_operating && !current.paused;

	// Byte-lane merge for the writable words
	function automatic logic [31:0] merge(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] strb);
		logic [31:0] result;
		result = old_word;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				result[8*i +: 8] = new_word[8*i +: 8];
		return result;
	endfunction : merge

	// ============================================================
	// Next-state logic
	always_comb
	begin
		logic [7:0]                  code;
		logic [7:0]                  log_addr;
		logic [15:0]                 feature;
		sanitize_pkg::cmd_class_type cls;
		logic                        mapped;
		logic [31:0]                 rd;
		code       = '0;
		log_addr   = '0;
		feature    = '0;
		cls        = sanitize_pkg::class_other;
		mapped     = 1'b0;
		rd         = '0;
		next_state = current;
		next_state.start = 1'b0;

		// Write address and data taken in either order
		if (s_axi_awvalid && current.awready)
		begin
			next_state.aw_held = 1'b1;
			next_state.awaddr  = s_axi_awaddr;
			next_state.awready = 1'b0;
		end
		if (s_axi_wvalid && current.wready)
		begin
			next_state.w_held = 1'b1;
			next_state.wdata  = s_axi_wdata;
			next_state.wstrb  = s_axi_wstrb;
			next_state.wready = 1'b0;
		end
		if (current.bvalid && s_axi_bready)
		begin
			next_state.bvalid  = 1'b0;
			next_state.awready = 1'b1;
			next_state.wready  = 1'b1;
		end

		// Engine completion; only allocatable sectors decide the outcome
		if (finish)
		begin
			if (engine_ok)
				next_state.state = sanitize_pkg::state_succeeded;
			else
				next_state.state = sanitize_pkg::state_failed;
		end

		// Perform a held write once both halves are in
		if (current.aw_held && current.w_held && !current.bvalid)
		begin
			next_state.aw_held = 1'b0;
			next_state.w_held  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = `SAN_RESP_OKAY;
			unique case (current.awaddr)
				`SAN_OFF_PARAM:
					next_state.param = merge(current.param, current.wdata,
						current.wstrb);
				`SAN_OFF_PATTERN:
					next_state.pattern = merge(current.pattern, current.wdata,
						current.wstrb);
				`SAN_OFF_CONFIG:
					next_state.config_bits = 2'(merge({30'h0,
						current.config_bits}, current.wdata, current.wstrb));
				`SAN_OFF_EVENT:
				begin
					// Hard and power-on resets free frozen and succeeded
					if (current.wdata[`SAN_EVT_HARD] ||
						current.wdata[`SAN_EVT_POWER_ON])
					begin
						if (current.state == sanitize_pkg::state_frozen ||
							current.state == sanitize_pkg::state_succeeded)
							next_state.state = sanitize_pkg::state_idle;
					end
					// Power-on keeps the operation; standby power-up pauses it
					if (current.wdata[`SAN_EVT_POWER_ON] &&
						current.state == sanitize_pkg::state_operating &&
						current.config_bits[`SAN_CFG_STANDBY])
						next_state.paused = 1'b1;
					// Software reset touches nothing here
				end
				`SAN_OFF_COMMAND:
				begin
					code     = current.wdata[`SAN_CMD_CODE_LSB +: 8];
					log_addr = current.wdata[`SAN_CMD_LOG_LSB +: 8];
					feature  = current.wdata[`SAN_CMD_FEAT_LSB +: 16];
					cls      = sanitize_pkg::cmd_class_type'(
						current.param[`SAN_PAR_CLASS_LSB +: 2]);
					next_state.done      = 1'b1;
					next_state.aborted   = 1'b0;
					next_state.error     = 1'b0;
					next_state.completed = 1'b0;
					next_state.lba_out   = '0;
					if (code == `SAN_CODE && feature == `SAN_FEAT_STATUS)
					begin
						// Status never disturbs idle, frozen or operating
						unique case (current.state)
							sanitize_pkg::state_succeeded:
							begin
								next_state.completed = 1'b1;
								next_state.state = sanitize_pkg::state_idle;
							end
							sanitize_pkg::state_failed:
								if (current.fail_mode &&
									current.param[`SAN_PAR_CLEARFAIL])
									next_state.state =
										sanitize_pkg::state_idle;
								else
								begin
									next_state.error   = 1'b1;
									next_state.lba_out = UNSUCCESS_CODE;
								end
							default:
							begin
							end
						endcase
					end
					else if (code == `SAN_CODE && (feature ==
						`SAN_FEAT_CRYPTO || feature == `SAN_FEAT_OVERWRITE))
					begin
						if (current.state == sanitize_pkg::state_frozen ||
							current.state == sanitize_pkg::state_operating ||
							(feature == `SAN_FEAT_CRYPTO &&
							!current.config_bits[`SAN_CFG_ENCRYPT]))
							next_state.aborted = 1'b1;
						else
						begin
							// Completes at once; the engine carries on
							next_state.state  = sanitize_pkg::state_operating;
							next_state.paused = 1'b0;
							next_state.start  = 1'b1;
							next_state.crypto = (feature == `SAN_FEAT_CRYPTO);
							next_state.fail_mode =
								current.param[`SAN_PAR_FAILMODE];
							next_state.invert =
								current.param[`SAN_PAR_INVERT];
							next_state.passes =
								current.param[`SAN_PAR_PASS_LSB +: PASS_WIDTH];
						end
					end
					else if (code == `SAN_CODE && feature == `SAN_FEAT_FREEZE)
					begin
						if (current.state == sanitize_pkg::state_idle ||
							current.state == sanitize_pkg::state_frozen)
							next_state.state = sanitize_pkg::state_frozen;
						else
							next_state.aborted = 1'b1;
					end
					else if (code == `SAN_CODE)
						next_state.aborted = 1'b1;
					else if (current.state == sanitize_pkg::state_operating)
					begin
						// Only the fixed allow-list passes during an operation
						if (!(cls == sanitize_pkg::class_exempt ||
							(cls == sanitize_pkg::class_log_read &&
							(log_addr == `SAN_LOG_A || log_addr == `SAN_LOG_B ||
							log_addr == `SAN_LOG_C))))
							next_state.aborted = 1'b1;
						// A media access wakes a paused operation but still fails
						if (cls == sanitize_pkg::class_media && current.paused)
							next_state.paused = 1'b0;
					end
				end
				default:
					next_state.bresp = `SAN_RESP_SLVERR;
			endcase
		end

		// Read channel: one answer at a time
		if (current.rvalid && s_axi_rready)
		begin
			next_state.rvalid  = 1'b0;
			next_state.arready = 1'b1;
		end
		if (s_axi_arvalid && current.arready)
		begin
			mapped = 1'b1;
			unique case (s_axi_araddr)
				`SAN_OFF_PARAM:   rd = current.param;
				`SAN_OFF_PATTERN: rd = current.pattern;
				`SAN_OFF_LBA_OUT: rd = current.lba_out;
				`SAN_OFF_CONFIG:  rd = {30'h0, current.config_bits};
				`SAN_OFF_RESULT:
				begin
					rd[`SAN_RES_DONE]      = current.done;
					rd[`SAN_RES_ABORTED]   = current.aborted;
					rd[`SAN_RES_ERROR]     = current.error;
					rd[`SAN_RES_COMPLETED] = current.completed;
					rd[`SAN_RES_PAUSED]    = current.paused;
					rd[`SAN_RES_STATE_LSB +: 3] = current.state;
					rd[`SAN_RES_PCT_LSB +: 7]   = percent;
				end
				`SAN_OFF_COMMAND: rd = '0;
				`SAN_OFF_EVENT:   rd = '0;
				default:          mapped = 1'b0;
			endcase
			next_state.arready = 1'b0;
			next_state.rvalid  = 1'b1;
			next_state.rdata   = rd;
			next_state.rresp   = mapped ? `SAN_RESP_OKAY : `SAN_RESP_SLVERR;
		end

		// Run level kept in a flop so the engine never sees a decode glitch
		next_state.run = next_state.state == sanitize_pkg::state_operating &&
			!next_state.paused;
	end

	// ============================================================
	// State register; idle is the never-sanitized starting point
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			current         <= '0;
			current.awready <= 1'b1;
			current.wready  <= 1'b1;
			current.arready <= 1'b1;
			current.config_bits <= `SAN_CONFIG_RESET;
		end
		else
			current <= next_state;
	end

	// ============================================================
	// Progress percentage for status queries
	progress_tracker u_progress
	(
		.aclk           (aclk),
		.aresetn        (aresetn),
		.start          (current.start),
		.finish         (finish),
		.running        (current.state == sanitize_pkg::state_operating),
		.engine_percent (engine_percent),
		.percent        (percent)
	);

	// ============================================================
	// Outputs, all straight from the state register
	assign s_axi_awready      = current.awready;
	assign s_axi_wready       = current.wready;
	assign s_axi_bvalid       = current.bvalid;
	assign s_axi_bresp        = current.bresp;
	assign s_axi_arready      = current.arready;
	assign s_axi_rvalid       = current.rvalid;
	assign s_axi_rresp        = current.rresp;
	assign s_axi_rdata        = current.rdata;
	assign engine_start       = current.start;
	// Run stays low while a standby power-up waits for media access
	assign engine_run         = current.run;
	assign engine_crypto      = current.crypto;
	assign engine_purge_cache = current.start;
	assign engine_pattern     = current.pattern;
	assign engine_passes      = current.passes;
	assign engine_invert      = current.invert;
	assign state              = current.state;

endmodule : sanitize_state_machine

// ---- testbench/sanitize_state_machine_asserts.sv ----
`timescale 1ns/1ns

// ============================================================
// Port checks of the sanitize state machine
module sanitize_state_machine_asserts
(
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic                        engine_start,
	input wire logic                        engine_run,
	input wire logic                        engine_purge_cache,
	input wire logic                        engine_done,
	input wire logic                        engine_ok,
	input wire sanitize_pkg::san_state_type state
);
	// One clock domain, so one clocking and one disable
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_state_code: assert property (state <= 3'h4)
		else $error("state code out of range");
	chk_purge_start: assert property ($rose(state == sanitize_pkg::state_operating) |-> engine_purge_cache && engine_start)
		else $error("operation entered without cache purge");
	chk_start_oper: assert property (engine_start |-> state == sanitize_pkg::state_operating)
		else $error("start without operating state");
	chk_run_oper: assert property (engine_run |-> state == sanitize_pkg::state_operating)
		else $error("engine runs outside operating");
	chk_done_good: assert property (engine_run && engine_done && engine_ok |=> state == sanitize_pkg::state_succeeded)
		else $error("clean finish not succeeded");
	chk_done_bad: assert property (engine_run && engine_done && !engine_ok |=> state == sanitize_pkg::state_failed)
		else $error("bad finish not failed");
	chk_oper_hold: assert property (state == sanitize_pkg::state_operating && !(engine_run && engine_done) |=> state == sanitize_pkg::state_operating)
		else $error("operating left early");
	chk_frozen_exit: assert property (state == sanitize_pkg::state_frozen |=> state inside {sanitize_pkg::state_frozen, sanitize_pkg::state_idle})
		else $error("frozen left wrongly");
	chk_idle_exit: assert property (state == sanitize_pkg::state_idle |=> state inside {sanitize_pkg::state_idle, sanitize_pkg::state_frozen, sanitize_pkg::state_operating})
		else $error("idle left wrongly");

	// Main scenarios reached
	cover property (engine_start);
	cover property (state == sanitize_pkg::state_succeeded);
	cover property (state == sanitize_pkg::state_failed);
endmodule : sanitize_state_machine_asserts

// ---- testbench/sanitize_engine_model.sv ----
`timescale 1ns/1ns

// ============================================================
// Behavioural media erase engine
module sanitize_engine_model
(
	input wire logic  aclk,
	input wire logic  engine_start,
	input wire logic  engine_run,
	input wire logic  hold,
	input wire logic  ok_cfg,
	output logic      engine_done,
	output logic      engine_ok,
	output logic [6:0] engine_percent
);
	logic [2:0] cnt = 3'h0;

	// Work runs in the background; hold stretches it for the bench
	initial engine_done = 1'b0;
	always @(posedge aclk)
	begin
		cnt <= engine_start ? 3'h0 : cnt + {2'h0, engine_run && cnt != 3'h7};
		// Start cycle still shows the old count, so it may not finish
		engine_done <= engine_run && !engine_start && !hold &&
			cnt >= 3'h4 && !engine_done;
	end

	// Result is only meaningful with done; otherwise the opposite
	assign engine_ok = engine_done ? ok_cfg : !ok_cfg;
	assign engine_percent = engine_run ? 7'h2a : 7'h55;
endmodule : sanitize_engine_model

// ---- testbench/sanitize_state_machine_tb.sv ----
`timescale 1ns/1ns
`include "sanitize_defines.svh"

module sanitize_state_machine_tb;
	logic aclk, aresetn, hold, ok_cfg;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, engine_pattern, r;
	logic [3:0] s_axi_wstrb, engine_passes;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, engine_start, engine_run;
	logic engine_crypto, engine_purge_cache, engine_invert;
	logic engine_done, engine_ok;
	logic [6:0] engine_percent;
	sanitize_pkg::san_state_type state;
	logic [7:0] logs [3] = '{8'he0, 8'h30, 8'h10};
	int n_errors, check_count, cycles;

	sanitize_state_machine i_sanitize_state_machine (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .engine_start, .engine_run, .engine_crypto,
		.engine_purge_cache, .engine_pattern, .engine_passes,
		.engine_invert, .engine_done, .engine_ok, .engine_percent, .state);
	sanitize_engine_model i_sanitize_engine_model (.aclk, .engine_start,
		.engine_run, .hold, .ok_cfg, .engine_done, .engine_ok,
		.engine_percent);

	// ============================================================
	// Clock and hang guard
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			test_done;
		end
	end

	// ============================================================
	// Bus tasks: hold each channel until its own handshake edge
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		r = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// Sanitize command: parameters first, then the command word
	task automatic op(input logic [15:0] f, input logic [31:0] p);
		wr(`SAN_OFF_PARAM, p);
		wr(`SAN_OFF_COMMAND, {f, 8'h00, `SAN_CODE});
	endtask : op
	task automatic st(input logic [2:0] e);
		rd(`SAN_OFF_RESULT);
		chk("state", 32'(e), 32'(r[10:8]));
	endtask : st
	// Poll a bounded number of times for the operation to end
	task automatic wait_end;
		rd(`SAN_OFF_RESULT);
		for (int i = 0; i < 40 && r[10:8] == 3'h2; i++)
			rd(`SAN_OFF_RESULT);
	endtask : wait_end
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// ============================================================
	// Main sequence
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, hold, ok_cfg} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		st(3'h0);
		op(`SAN_FEAT_STATUS, 0);
		st(3'h0);
		wr(`SAN_OFF_EVENT, 32'h3);
		st(3'h0);
		op(`SAN_FEAT_FREEZE, 0);
		st(3'h1);
		op(`SAN_FEAT_OVERWRITE, 0);
		st(3'h1);
		chk("aborted", 1, 32'(r[1]));
		op(`SAN_FEAT_STATUS, 0);
		st(3'h1);
		wr(`SAN_OFF_EVENT, 32'h1);
		st(3'h0);
		op(`SAN_FEAT_FREEZE, 0);
		wr(`SAN_OFF_EVENT, 32'h2);
		st(3'h0);
		wr(`SAN_OFF_CONFIG, 0);
		op(`SAN_FEAT_CRYPTO, 0);
		st(3'h0);
		chk("aborted", 1, 32'(r[1]));
		// Long overwrite: lock-out, events and progress
		hold <= 1'b1;
		ok_cfg <= 1'b1;
		wr(`SAN_OFF_PATTERN, 32'hc3a5_5a3c);
		op(`SAN_FEAT_OVERWRITE, 32'h310);
		st(3'h2);
		chk("aborted", 0, 32'(r[1]));
		chk("pattern", 32'hc3a5_5a3c, engine_pattern);
		chk("passes", 3, 32'(engine_passes));
		chk("invert", 1, 32'(engine_invert));
		chk("crypto", 0, 32'(engine_crypto));
		op(`SAN_FEAT_STATUS, 0);
		st(3'h2);
		chk("percent", 32'h2a, 32'(r[22:16]));
		wr(`SAN_OFF_PARAM, 0);
		wr(`SAN_OFF_COMMAND, 32'hec);
		st(3'h2);
		chk("aborted", 1, 32'(r[1]));
		wr(`SAN_OFF_PARAM, 1);
		wr(`SAN_OFF_COMMAND, 32'hec);
		st(3'h2);
		chk("aborted", 0, 32'(r[1]));
		wr(`SAN_OFF_PARAM, 2);
		foreach (logs[i])
		begin
			wr(`SAN_OFF_COMMAND, {16'h0, logs[i], 8'h2f});
			st(3'h2);
			chk("aborted", 0, 32'(r[1]));
		end
		wr(`SAN_OFF_COMMAND, 32'h202f);
		st(3'h2);
		chk("aborted", 1, 32'(r[1]));
		wr(`SAN_OFF_EVENT, 32'h7);
		st(3'h2);
		hold <= 1'b0;
		wait_end;
		chk("state", 4, 32'(r[10:8]));
		chk("percent", 32'(`SAN_PCT_DONE), 32'(r[22:16]));
		op(`SAN_FEAT_STATUS, 0);
		st(3'h0);
		chk("completed", 1, 32'(r[3]));
		// Failing crypto scramble with failure mode set
		wr(`SAN_OFF_CONFIG, 1);
		ok_cfg <= 1'b0;
		op(`SAN_FEAT_CRYPTO, 32'h4);
		chk("crypto", 1, 32'(engine_crypto));
		wait_end;
		op(`SAN_FEAT_STATUS, 0);
		st(3'h3);
		chk("error", 1, 32'(r[2]));
		rd(`SAN_OFF_LBA_OUT);
		chk("lba_out", 1, r);
		wr(`SAN_OFF_EVENT, 32'h3);
		st(3'h3);
		op(`SAN_FEAT_STATUS, 32'h8);
		st(3'h0);
		// Failure without failure mode cannot be cleared
		op(`SAN_FEAT_OVERWRITE, 0);
		wait_end;
		op(`SAN_FEAT_STATUS, 32'h8);
		st(3'h3);
		hold <= 1'b1;
		ok_cfg <= 1'b1;
		op(`SAN_FEAT_OVERWRITE, 0);
		st(3'h2);
		hold <= 1'b0;
		wait_end;
		wr(`SAN_OFF_EVENT, 32'h2);
		st(3'h0);
		// Power-up in standby pauses until a media access
		wr(`SAN_OFF_CONFIG, 3);
		hold <= 1'b1;
		op(`SAN_FEAT_OVERWRITE, 0);
		wr(`SAN_OFF_EVENT, 32'h2);
		st(3'h2);
		chk("paused", 1, 32'(r[4]));
		hold <= 1'b0;
		wr(`SAN_OFF_PARAM, 3);
		wr(`SAN_OFF_COMMAND, 32'h25);
		rd(`SAN_OFF_RESULT);
		chk("aborted", 1, 32'(r[1]));
		wait_end;
		chk("state", 4, 32'(r[10:8]));
		// Unmapped place answers with an error
		rd(8'h40);
		chk("rresp", 32'(`SAN_RESP_SLVERR), 32'(resp));
		wr(8'h40, 32'h1);
		chk("bresp", 32'(`SAN_RESP_SLVERR), 32'(resp));
		test_done;
	end
endmodule : sanitize_state_machine_tb

bind sanitize_state_machine sanitize_state_machine_asserts
	i_sanitize_state_machine_asserts (.aclk(aclk), .aresetn(aresetn),
	.engine_start(engine_start), .engine_run(engine_run),
	.engine_purge_cache(engine_purge_cache), .engine_done(engine_done),
	.engine_ok(engine_ok), .state(state));
